// *** rtl/iam_pkg.sv ***
/*
 pointer map constants and carrier types for the indirect address mapper.
 assumes a 16-bit pointer, 8-bit data and a 15-bit program flash address.
*/
package iam_pkg;
  localparam logic [15:0] LIN_BASE = 16'h2000;
  localparam logic [15:0] LIN_LAST = 16'h29af;
  localparam logic [15:0] LIN_SPAN = 16'h09b0;
  localparam logic [15:0] GPR_BLOCK = 16'h0050;
  localparam logic [6:0] GPR_FIRST = 7'h20;
  localparam int FLASH_BIT = 15;
  localparam int FLASH_AW = 15;
  localparam int FLASH_DW = 14;
  localparam int BANK_W = 5;
  localparam logic [7:0] UNIMP_READ = 8'h00;

  // decoded target of one indirect access
  typedef enum logic [1:0] {
    IAM_TGT_RAM,
    IAM_TGT_FLASH,
    IAM_TGT_NONE
  } iam_target_t;

  // one request from the core
  typedef struct packed {
    logic rd;
    logic wr;
    logic [7:0] ptr_hi;
    logic [7:0] ptr_lo;
    logic [7:0] wdata;
  } iam_req_t;

  // banked ram access towards the storage
  typedef struct packed {
    logic rd;
    logic wr;
    logic [BANK_W-1:0] bank;
    logic [6:0] offs;
    logic [7:0] wdata;
  } iam_ram_t;
endpackage

// *** rtl/iam_mapper.sv ***
/*
 indirect address mapper: decodes the core's pointer onto banked ram,
 program flash or a zero read, and stalls the core on flash reads and writes.
 assumes ram and flash answer combinationally in the same cycle, and that
 the core holds its request while stall is high.
*/
`timescale 1ns/1ps
`default_nettype none
module iam_mapper (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // core side
  input wire iam_pkg::iam_req_t req,
  output logic stall,
  output logic [7:0] rdata,
  output logic rvalid,
  // banked ram side
  output iam_pkg::iam_ram_t ram,
  input wire logic [7:0] ram_rdata,
  // program flash side
  output logic flash_rd,
  output logic [iam_pkg::FLASH_AW-1:0] flash_addr,
  input wire logic [iam_pkg::FLASH_DW-1:0] flash_rdata
);

  // an access is either fresh or in the one wait cycle after its stalled flash cycle
  typedef enum logic {IAM_IDLE, IAM_WAIT} iam_state_t;

  // bank field width, and the highest bank number the divider can return
  localparam int BANK_W_L = iam_pkg::BANK_W;
  localparam int BANK_TOP = (1 << BANK_W_L) - 1;

  // pointer, window offset and the decoded ram address
  logic [15:0] ptr;
  logic [15:0] lin_off;
  logic [BANK_W_L-1:0] bank;
  logic [6:0] byte_off;
  iam_pkg::iam_target_t tgt;
  iam_state_t state_q, state_d;
  logic [7:0] rdata_q, rdata_d;
  logic rvalid_q, rvalid_d;

  ////////////////////////////////////////////////////////////////////////
  // decode, freshly from the byte pair each cycle
  assign ptr = {req.ptr_hi, req.ptr_lo};
  assign lin_off = ptr - iam_pkg::LIN_BASE;

  // divide by 80 without a divider: window spans fewer than 32 blocks.
  // the largest multiple of 80 not above the offset gives the bank, and
  // what is left over gives the byte; outside the window the result is
  // junk, but then no strobe goes out, so it never reaches storage
  always_comb begin
    logic [15:0] rem;
    rem = lin_off;
    bank = '0;
    for (int i = BANK_TOP; i > 0; i--) begin
      if (rem >= iam_pkg::GPR_BLOCK * 16'(i) && bank == '0 && i != 0) begin
        bank = BANK_W_L'(i);
        rem = rem - iam_pkg::GPR_BLOCK * 16'(i);
      end
    end
    // remainder stays below 80, so common ram at 0x70..0x7f is never hit
    byte_off = 7'(rem) + iam_pkg::GPR_FIRST;
  end

  // pick the target; the flash half wins over everything else, and any
  // pointer that is neither window nor flash falls to the zero read
  always_comb begin
    if (ptr[iam_pkg::FLASH_BIT]) begin
      tgt = iam_pkg::IAM_TGT_FLASH;
    end else if (ptr >= iam_pkg::LIN_BASE && ptr <= iam_pkg::LIN_LAST) begin
      tgt = iam_pkg::IAM_TGT_RAM;
    end else begin
      tgt = iam_pkg::IAM_TGT_NONE;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // storage strobes; flash has no write path at all, so a write into the
  // flash half only costs the stall cycle and leaves every array alone
  always_comb begin
    ram.rd = req.rd && tgt == iam_pkg::IAM_TGT_RAM;
    ram.wr = req.wr && tgt == iam_pkg::IAM_TGT_RAM;
    ram.bank = bank;
    ram.offs = byte_off;
    ram.wdata = req.wdata;
  end
  assign flash_addr = ptr[iam_pkg::FLASH_AW-1:0];
  assign flash_rd = req.rd && tgt == iam_pkg::IAM_TGT_FLASH && state_q == IAM_IDLE;

  ////////////////////////////////////////////////////////////////////////
  // sequencing: flash access holds the core one extra cycle.
  // the flash byte is captured in the stalled cycle, while flash_rd is up,
  // and held through the wait cycle so it stands when rvalid rises
  always_comb begin
    state_d = IAM_IDLE;
    rdata_d = rdata_q;
    rvalid_d = 1'b0;
    unique case (state_q)
      IAM_IDLE: begin
        if ((req.rd || req.wr) && tgt == iam_pkg::IAM_TGT_FLASH) begin
          state_d = IAM_WAIT;
          if (req.rd) begin
            rdata_d = flash_rdata[7:0];
          end
        end else if (req.rd) begin
          rvalid_d = 1'b1;
          rdata_d = (tgt == iam_pkg::IAM_TGT_RAM) ? ram_rdata : iam_pkg::UNIMP_READ;
        end
      end
      IAM_WAIT: begin
        rvalid_d = req.rd;
      end
    endcase
  end

  // state, read data and its valid pulse
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state_q <= IAM_IDLE;
      rdata_q <= 8'h00;
      rvalid_q <= 1'b0;
    end else begin
      state_q <= state_d;
      rdata_q <= rdata_d;
      rvalid_q <= rvalid_d;
    end
  end

  // stall while a flash access is in its first cycle
  assign stall = state_q == IAM_IDLE && (req.rd || req.wr) && tgt == iam_pkg::IAM_TGT_FLASH;
  assign rdata = rdata_q;
  assign rvalid = rvalid_q;

  ////////////////////////////////////////////////////////////////////////
  // checks
  // flash read: stalled cycle, one quiet cycle, then the byte stands
  sequence s_flash_start;
    stall && req.rd;
  endsequence
  sequence s_flash_done;
    !stall ##1 rvalid;
  endsequence
  // flash write: stalled cycle, one quiet cycle, then no data pulse
  sequence s_flash_wr_start;
    stall && req.wr;
  endsequence
  sequence s_flash_wr_done;
    !stall ##1 !rvalid;
  endsequence
  // ram read at a bank's last byte, then at the very next pointer
  sequence s_bank_last;
    ram.rd && ram.offs == 7'h6f && ptr != 16'h29af;
  endsequence
  sequence s_next_ptr;
    ram.rd && ptr == $past(ptr) + 16'h1;
  endsequence

  // flash timing: exactly one extra cycle, for reads and writes alike
  chk_flash_extra: assert property (@(posedge core_clk) disable iff (rst)
    s_flash_start |=> s_flash_done)
    else $error("flash read not one extra cycle");
  chk_flash_wr_extra: assert property (@(posedge core_clk) disable iff (rst)
    s_flash_wr_start |=> s_flash_wr_done)
    else $error("flash write not one extra cycle");
  chk_stall_single: assert property (@(posedge core_clk) disable iff (rst)
    stall |=> !stall)
    else $error("stall longer than one cycle");

  // flash data path: strobe, address and the low byte only
  chk_flash_strobe: assert property (@(posedge core_clk) disable iff (rst)
    s_flash_start |-> flash_rd)
    else $error("flash read without strobe");
  chk_flash_addr: assert property (@(posedge core_clk) disable iff (rst)
    flash_rd |-> flash_addr == ptr[14:0])
    else $error("flash address wrong");
  chk_flash_low: assert property (@(posedge core_clk) disable iff (rst)
    s_flash_start |=> ##1 rdata == $past(flash_rdata[7:0], 2))
    else $error("flash byte wrong");
  chk_flash_nowr: assert property (@(posedge core_clk) disable iff (rst)
    ptr[15] |-> !ram.wr)
    else $error("write reached storage from flash half");

  // zero read for space that is neither window nor flash
  chk_unimp_zero: assert property (@(posedge core_clk) disable iff (rst)
    req.rd && tgt == iam_pkg::IAM_TGT_NONE |=> rvalid && rdata == 8'h00)
    else $error("unimp not zero");
  chk_unimp_quiet: assert property (@(posedge core_clk) disable iff (rst)
    tgt == iam_pkg::IAM_TGT_NONE |-> !ram.rd && !ram.wr && !flash_rd)
    else $error("unimp space strobed storage");

  // window decode: range, bank arithmetic, common area and bank steps
  chk_window_range: assert property (@(posedge core_clk) disable iff (rst)
    (ram.rd || ram.wr) |-> ptr >= 16'h2000 && ptr <= 16'h29af)
    else $error("ram hit outside window");
  chk_ram_data: assert property (@(posedge core_clk) disable iff (rst)
    ram.rd |=> rvalid && rdata == $past(ram_rdata))
    else $error("ram read data wrong");
  chk_no_common: assert property (@(posedge core_clk) disable iff (rst)
    (ram.rd || ram.wr) |-> ram.offs >= 7'h20 && ram.offs <= 7'h6f)
    else $error("common ram mapped");
  chk_bank_math: assert property (@(posedge core_clk) disable iff (rst)
    ram.rd |-> 16'(ram.bank) * 16'd80 + 16'(ram.offs) - 16'h20 == ptr - 16'h2000)
    else $error("bank math wrong");
  chk_ptr_pair: assert property (@(posedge core_clk) disable iff (rst)
    ram.wr |-> 16'(ram.bank) * 16'd80 + 16'(ram.offs) - 16'h20
      == {req.ptr_hi, req.ptr_lo} - 16'h2000)
    else $error("write address not from pointer bytes");
  chk_bank_step: assert property (@(posedge core_clk) disable iff (rst)
    s_bank_last ##1 s_next_ptr |-> ram.offs == 7'h20 && ram.bank == $past(ram.bank) + 5'h1)
    else $error("bank step gap");

endmodule
`default_nettype wire

// *** tb/iam_mem_model.sv ***
/*
 far-side model: banked ram and read-only program flash.
 assumes answers are wanted in the same cycle.
*/
`timescale 1ns/1ps
`default_nettype none
module iam_mem_model (
  // clock
  input wire logic core_clk,
  // ram side
  input wire iam_pkg::iam_ram_t ram,
  output logic [7:0] ram_rdata,
  // flash side
  input wire logic flash_rd,
  input wire logic [iam_pkg::FLASH_AW-1:0] flash_addr,
  output logic [iam_pkg::FLASH_DW-1:0] flash_rdata
);
  logic [7:0] mem [0:31][0:127];
  logic [13:0] word;
  // ram stores only on its write strobe
  always @(posedge core_clk) begin
    if (ram.wr) mem[ram.bank][ram.offs] <= ram.wdata;
  end
  // unstrobed answers show inverted data
  assign ram_rdata = ram.rd ? mem[ram.bank][ram.offs] : ~mem[ram.bank][ram.offs];
  assign word = {flash_addr[5:0], flash_addr[14:7]} ^ 14'h2a5a; // no write path
  assign flash_rdata = flash_rd ? word : ~word;
endmodule
`default_nettype wire

// *** tb/test_iam_mapper.sv ***
/*
 self-checking bench for the indirect address mapper.
 assumes the memory model beside it.
*/
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin miscompares++; \
  $display("Error %0t: got %h want %h", $time, a, b); end end
module test_iam_mapper;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  iam_pkg::iam_req_t req = '0;
  logic stall, rvalid, flash_rd;
  logic [7:0] rdata, ram_rdata;
  iam_pkg::iam_ram_t ram;
  logic [14:0] flash_addr;
  logic [13:0] flash_rdata;
  int miscompares = 0;
  int total_checks = 0;
  int cycles = 0;
  always #12.5 core_clk = ~core_clk;
  iam_mapper dut_u (.core_clk(core_clk), .rst(rst), .req(req), .stall(stall),
    .rdata(rdata), .rvalid(rvalid), .ram(ram), .ram_rdata(ram_rdata),
    .flash_rd(flash_rd), .flash_addr(flash_addr), .flash_rdata(flash_rdata));
  iam_mem_model mem_u (.core_clk(core_clk), .ram(ram), .ram_rdata(ram_rdata),
    .flash_rd(flash_rd), .flash_addr(flash_addr), .flash_rdata(flash_rdata));
  ////////////////////////////////////////
  task automatic close_out();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // low byte of the model's flash word
  function automatic logic [7:0] fl(input logic [15:0] p);
    return p[14:7] ^ 8'h5a;
  endfunction
  // one access, held through any stall, then judged
  task automatic acc(input logic [15:0] p, input logic w, input logic [7:0] d, e);
    logic [15:0] o;
    logic win;
    o = p - 16'h2000;
    win = p >= 16'h2000 && p <= 16'h29af;
    @(negedge core_clk);
    req = '{rd: !w, wr: w, ptr_hi: p[15:8], ptr_lo: p[7:0], wdata: d};
    #1;
    `CHK(stall, p[15])
    `CHK(ram.rd | ram.wr, win)
    `CHK(flash_rd, p[15] & !w)
    if (win) `CHK({ram.bank, ram.offs}, {5'(o / 80), 7'(o % 80 + 32)})
    if (win) `CHK(ram.offs < 7'h70, 1'b1)
    if (p[15]) `CHK(flash_addr, p[14:0])
    @(negedge core_clk);
    if (p[15]) begin
      `CHK(rvalid, 1'b0)
      `CHK(stall, 1'b0)
      @(negedge core_clk);
    end
    `CHK(rvalid, !w)
    if (!w) `CHK(rdata, e)
    req = '0;
  endtask
  ////////////////////////////////////////
  task automatic t_bank_step();
    acc(16'h204f, 1, 8'ha1, 0);
    acc(16'h2050, 1, 8'hb2, 0);
    acc(16'h204f, 0, 0, 8'ha1);
    acc(16'h2050, 0, 0, 8'hb2);
    $display("done bank step");
  endtask
  // back-to-back reads walking across a bank boundary, one per cycle
  task automatic t_burst();
    logic [7:0] want [0:3];
    logic [15:0] p;
    want = '{8'hc3, 8'ha1, 8'hb2, 8'hd4};
    acc(16'h204e, 1, 8'hc3, 0);
    acc(16'h2051, 1, 8'hd4, 0);
    for (int k = 0; k < 5; k++) begin
      @(negedge core_clk);
      if (k > 0) begin
        `CHK(rvalid, 1'b1)
        `CHK(rdata, want[k-1])
      end
      p = 16'h204e + 16'(k);
      req = '{rd: k < 4, wr: 1'b0, ptr_hi: p[15:8], ptr_lo: p[7:0], wdata: 8'h00};
    end
    $display("done burst");
  endtask
  task automatic t_edges();
    acc(16'h2000, 1, 8'h11, 0);
    acc(16'h29af, 1, 8'h3c, 0);
    acc(16'h2000, 0, 0, 8'h11);
    acc(16'h29af, 0, 0, 8'h3c);
    acc(16'h29b0, 0, 0, 8'h00);
    acc(16'h1ff0, 0, 0, 8'h00);
    $display("done window edges");
  endtask
  task automatic t_flash();
    acc(16'h8000, 0, 0, fl(16'h8000));
    acc(16'hffff, 0, 0, fl(16'hffff));
    acc(16'ha04f, 1, 8'h77, 0);
    acc(16'ha04f, 0, 0, fl(16'ha04f));
    acc(16'h204f, 0, 0, 8'ha1);
    $display("done flash");
  endtask
  // hang guard
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 3000) begin
      miscompares++;
      close_out();
    end
  end
  initial begin
    repeat (6) @(posedge core_clk);
    @(negedge core_clk);
    rst = 1'b0;
    t_bank_step();
    t_burst();
    t_edges();
    t_flash();
    close_out();
  end
endmodule
`default_nettype wire
